// File: logic/lptpc_top.sv
`timescale 1ns/1ps
`default_nettype none
module lptpc_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        shared_pin_zero_in,
	output logic             shared_pin_zero_out,
	output logic             shared_pin_zero_oe,
	output logic             panel_power_out,
	output logic             line_pulse,
	output logic             frame_pulse,
	output logic             panel_data_enable
);
	import lptpc_pkg::*;

	// eight-pixel steps to pixels
	function automatic logic [10:0] f_px8(input logic [7:0] n);
		return {n, 3'h0};
	endfunction : f_px8

	logic [7:0]  panel_type_reg;
	logic [3:0]  power_save_reg;
	logic [6:0]  hsize_reg;
	logic [9:0]  vsize_reg;
	logic [4:0]  line_start_reg;
	logic [4:0]  hblank_reg;
	logic [5:0]  frame_start_reg;
	logic [5:0]  vblank_reg;
	logic        pin_cfg_reg;
	logic        pin_ctl_reg;
	logic [10:0] pix_cnt_reg;
	logic [10:0] line_cnt_reg;
	logic        panel_off_reg;
	logic        line_pulse_reg;
	logic        frame_pulse_reg;
	logic        data_en_reg;

	logic        active_matrix;
	logic        override;
	logic        hw_ps_en;
	logic        power_save;
	logic [10:0] h_active;
	logic [10:0] h_total;
	logic [10:0] line_pos;
	logic [10:0] v_active;
	logic [10:0] v_total;
	logic [10:0] frame_line;
	logic        line_end;
	logic        frame_end;
	logic [7:0]  reg_idx;
	logic        addr_ok;
	logic [7:0]  rd_val;
	logic        wr_en;

	assign active_matrix = panel_type_reg[POS_ACTIVE_MATRIX];
	assign override      = power_save_reg[POS_OVERRIDE];
	assign hw_ps_en      = power_save_reg[POS_HW_PS_EN];

	// reserved codes 01 and 10 are treated as normal operation
	assign power_save = (power_save_reg[1:0] == SW_PS_SAVE)
		|| (hw_ps_en && shared_pin_zero_in);

	// shared pin zero: hardware power save input wins over its pin config
	assign shared_pin_zero_oe  = !hw_ps_en && pin_cfg_reg;
	assign shared_pin_zero_out = pin_ctl_reg;

	// line geometry in pixels
	assign h_active = f_px8({1'b0, hsize_reg} + 8'h01);
	assign h_total  = h_active + f_px8({3'h0, hblank_reg} + HBLANK_ADD);
	// passive panels put the line pulse right at the start of blanking
	assign line_pos = active_matrix
		? h_active + f_px8({3'h0, line_start_reg} + LINE_START_ADD)
		: h_active;

	// frame geometry in lines; a zero blanking field still leaves one line
	assign v_active = {1'b0, vsize_reg} + 11'h001;
	assign v_total  = v_active + ((vblank_reg == 6'h00) ? 11'h001 : {5'h00, vblank_reg});
	assign frame_line = active_matrix
		? v_active - 11'h001 + {5'h00, frame_start_reg}
		: v_active;

	// compare at-or-past the end, so a counter left beyond a geometry that
	// software just shrank still wraps instead of running round all 2048 counts
	assign line_end  = (pix_cnt_reg >= h_total - 11'h001);
	assign frame_end = line_end && (line_cnt_reg >= v_total - 11'h001);

	// pixel and line counters, one pixel per clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pix_cnt_reg  <= 11'h000;
			line_cnt_reg <= 11'h000;
		end else if (line_end) begin
			pix_cnt_reg  <= 11'h000;
			line_cnt_reg <= frame_end ? 11'h000 : line_cnt_reg + 11'h001;
		end else begin
			pix_cnt_reg <= pix_cnt_reg + 11'h001;
		end
	end

	// raw panel timing, registered so outputs come from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_pulse_reg  <= 1'b0;
			frame_pulse_reg <= 1'b0;
			data_en_reg     <= 1'b0;
		end else begin
			line_pulse_reg  <= (pix_cnt_reg >= line_pos)
				&& (pix_cnt_reg < line_pos + LINE_PULSE_PX);
			frame_pulse_reg <= (line_cnt_reg == frame_line);
			data_en_reg     <= (pix_cnt_reg < h_active) && (line_cnt_reg < v_active);
		end
	end

	// panel on/off: the sequencer only switches at a frame boundary so the
	// panel never sees a torn frame; the override skips that wait when switching off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			panel_off_reg <= 1'b1;
		end else if (override && power_save) begin
			panel_off_reg <= 1'b1;
		end else if (frame_end) begin
			panel_off_reg <= power_save;
		end
	end

	assign panel_power_out   = !panel_off_reg;
	assign line_pulse        = line_pulse_reg && !panel_off_reg;
	assign frame_pulse       = frame_pulse_reg && !panel_off_reg;
	assign panel_data_enable = data_en_reg && !panel_off_reg;

	// apb decode: word aligned, index in address bits above the byte lane
	assign reg_idx = paddr[9:2];
	assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) && (
		reg_idx == IDX_PANEL_TYPE || reg_idx == IDX_POWER_SAVE ||
		reg_idx == IDX_HSIZE || reg_idx == IDX_VSIZE_LO ||
		reg_idx == IDX_VSIZE_HI || reg_idx == IDX_LINE_START ||
		reg_idx == IDX_HBLANK || reg_idx == IDX_FRAME_START ||
		reg_idx == IDX_VBLANK || reg_idx == IDX_PIN_CFG ||
		reg_idx == IDX_PIN_CTL || reg_idx == IDX_STATUS);
	assign wr_en  = psel && penable && pwrite && addr_ok;
	// one wait-free access phase; read data was captured in setup
	assign pready = 1'b1;

	// read mux; the control bit reads the pin while the pin is an input
	always_comb begin
		rd_val = 8'h00;
		unique case (reg_idx)
			IDX_PANEL_TYPE:  rd_val = panel_type_reg;
			IDX_POWER_SAVE:  rd_val = {4'h0, power_save_reg};
			IDX_HSIZE:       rd_val = {1'b0, hsize_reg};
			IDX_VSIZE_LO:    rd_val = vsize_reg[7:0];
			IDX_VSIZE_HI:    rd_val = {6'h00, vsize_reg[9:8]};
			IDX_LINE_START:  rd_val = {3'h0, line_start_reg};
			IDX_HBLANK:      rd_val = {3'h0, hblank_reg};
			IDX_FRAME_START: rd_val = {2'h0, frame_start_reg};
			IDX_VBLANK:      rd_val = {2'h0, vblank_reg};
			IDX_PIN_CFG:     rd_val = {7'h00, pin_cfg_reg};
			IDX_PIN_CTL:     rd_val = {7'h00,
				shared_pin_zero_oe ? pin_ctl_reg : shared_pin_zero_in};
			IDX_STATUS:      rd_val = {5'h00, shared_pin_zero_in, panel_off_reg, power_save};
			default:         rd_val = 8'h00;
		endcase
	end

	// read data and error are sampled in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			prdata  <= (addr_ok && !pwrite) ? {24'h00_0000, rd_val} : 32'h0000_0000;
			pslverr <= !addr_ok;
		end
	end

	// register writes take effect at the access edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			panel_type_reg  <= RST_PANEL_TYPE;
			power_save_reg  <= RST_POWER_SAVE;
			hsize_reg       <= RST_HSIZE;
			vsize_reg       <= RST_VSIZE;
			line_start_reg  <= RST_LINE_START;
			hblank_reg      <= RST_HBLANK;
			frame_start_reg <= RST_FRAME_START;
			vblank_reg      <= RST_VBLANK;
			pin_cfg_reg     <= 1'b0;
			pin_ctl_reg     <= 1'b0;
		end else if (wr_en) begin
			unique case (reg_idx)
				IDX_PANEL_TYPE:  panel_type_reg  <= pwdata[7:0];
				IDX_POWER_SAVE:  power_save_reg  <= pwdata[3:0];
				IDX_HSIZE:       hsize_reg       <= pwdata[6:0];
				IDX_VSIZE_LO:    vsize_reg[7:0]  <= pwdata[7:0];
				IDX_VSIZE_HI:    vsize_reg[9:8]  <= pwdata[1:0];
				IDX_LINE_START:  line_start_reg  <= pwdata[4:0];
				IDX_HBLANK:      hblank_reg      <= pwdata[4:0];
				IDX_FRAME_START: frame_start_reg <= pwdata[5:0];
				IDX_VBLANK:      vblank_reg      <= pwdata[5:0];
				IDX_PIN_CFG:     pin_cfg_reg     <= pwdata[0];
				IDX_PIN_CTL:     pin_ctl_reg     <= pwdata[0];
				default:         pin_ctl_reg     <= pin_ctl_reg;
			endcase
		end
	end

	// checks on the timing, power and pin logic
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_override_off;
		override && power_save |=> !panel_power_out && !line_pulse && !panel_data_enable;
	endproperty
	a_override_off: assert property (p_override_off) else $error("override did not cut panel");

	property p_seq_hold;
		!override && !frame_end && (power_save != panel_off_reg) |=> $stable(panel_off_reg);
	endproperty
	a_seq_hold: assert property (p_seq_hold) else $error("panel state moved off frame end");

	property p_hw_input;
		hw_ps_en |-> !shared_pin_zero_oe && (shared_pin_zero_in == 1'b1 ? power_save : 1'b1);
	endproperty
	a_hw_input: assert property (p_hw_input) else $error("hardware power save input misused");

	property p_pin_drive;
		!hw_ps_en |-> (shared_pin_zero_oe == pin_cfg_reg) && (shared_pin_zero_out == pin_ctl_reg);
	endproperty
	a_pin_drive: assert property (p_pin_drive) else $error("pin zero drive wrong");

	property p_sw_normal;
		(power_save_reg[1:0] == SW_PS_NORMAL) && !hw_ps_en |-> !power_save;
	endproperty
	a_sw_normal: assert property (p_sw_normal) else $error("normal code gave power save");

	property p_active_px;
		$fell(data_en_reg) && $stable(hsize_reg) && ($past(hsize_reg, 2) == hsize_reg)
			&& $stable(vsize_reg) && ($past(vsize_reg, 2) == vsize_reg)
			|-> $past(pix_cnt_reg) == h_active;
	endproperty
	a_active_px: assert property (p_active_px) else $error("active pixel count wrong");

	property p_line_pos;
		$rose(line_pulse_reg) && $stable(line_pos)
			&& ($past(line_pos, 2) == line_pos) |->
			$past(pix_cnt_reg) == (active_matrix
			? h_active + f_px8({3'h0, line_start_reg} + 8'h02) : h_active);
	endproperty
	a_line_pos: assert property (p_line_pos) else $error("line pulse misplaced");

	property p_line_wrap;
		(pix_cnt_reg == h_active + f_px8({3'h0, hblank_reg} + 8'h04) - 11'h001)
			|=> pix_cnt_reg == 11'h000;
	endproperty
	a_line_wrap: assert property (p_line_wrap) else $error("blank period wrong");

	property p_frame_pos;
		$rose(frame_pulse_reg) && active_matrix && $stable(active_matrix)
			&& $stable(frame_start_reg) && $stable(vsize_reg) |->
			$past(line_cnt_reg) == {1'b0, vsize_reg} + {5'h00, frame_start_reg};
	endproperty
	a_frame_pos: assert property (p_frame_pos) else $error("frame pulse misplaced");

	property p_seq_on;
		!override && frame_end |=> panel_off_reg == $past(power_save);
	endproperty
	a_seq_on: assert property (p_seq_on) else $error("panel state missed frame end");

	property p_hw_idle;
		!hw_ps_en && (power_save_reg[1:0] != SW_PS_SAVE) |-> !power_save;
	endproperty
	a_hw_idle: assert property (p_hw_idle) else $error("power save without a source");

	property p_passive_fp;
		$rose(frame_pulse_reg) && !active_matrix && $stable(active_matrix)
			&& $stable(vsize_reg) |->
			$past(line_cnt_reg) == v_active;
	endproperty
	a_passive_fp: assert property (p_passive_fp) else $error("passive frame pulse moved");

	property p_pin_status;
		psel && !penable && !pwrite && addr_ok && (reg_idx == IDX_PIN_CTL)
			&& !shared_pin_zero_oe |=> prdata == {31'h0000_0000, $past(shared_pin_zero_in)};
	endproperty
	a_pin_status: assert property (p_pin_status) else $error("pin status read wrong");
endmodule : lptpc_top
`default_nettype wire

// File: logic/lptpc_pkg.sv
`default_nettype none
package lptpc_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_PANEL_TYPE = 8'h01;
	localparam logic [7:0] IDX_POWER_SAVE = 8'h03;
	localparam logic [7:0] IDX_HSIZE      = 8'h04;
	localparam logic [7:0] IDX_VSIZE_LO   = 8'h05;
	localparam logic [7:0] IDX_VSIZE_HI   = 8'h06;
	localparam logic [7:0] IDX_LINE_START = 8'h07;
	localparam logic [7:0] IDX_HBLANK     = 8'h08;
	localparam logic [7:0] IDX_FRAME_START = 8'h09;
	localparam logic [7:0] IDX_VBLANK     = 8'h0a;
	localparam logic [7:0] IDX_PIN_CFG    = 8'h18;
	localparam logic [7:0] IDX_PIN_CTL    = 8'h19;
	localparam logic [7:0] IDX_STATUS     = 8'h1c;
	// field positions
	localparam int POS_ACTIVE_MATRIX = 7;
	localparam int POS_OVERRIDE      = 3;
	localparam int POS_HW_PS_EN      = 2;
	// software power-save codes
	localparam logic [1:0] SW_PS_SAVE   = 2'h0;
	localparam logic [1:0] SW_PS_NORMAL = 2'h3;
	// reset values
	localparam logic [7:0] RST_PANEL_TYPE  = 8'h00;
	localparam logic [3:0] RST_POWER_SAVE  = 4'h0;
	localparam logic [6:0] RST_HSIZE       = 7'h27;
	localparam logic [9:0] RST_VSIZE       = 10'h0ef;
	localparam logic [4:0] RST_LINE_START  = 5'h00;
	localparam logic [4:0] RST_HBLANK      = 5'h00;
	localparam logic [5:0] RST_FRAME_START = 6'h01;
	localparam logic [5:0] RST_VBLANK      = 6'h01;
	// line pulse width in pixels, and the 8-pixel step offsets
	localparam logic [10:0] LINE_PULSE_PX = 11'h008;
	localparam logic [7:0]  LINE_START_ADD = 8'h02;
	localparam logic [7:0]  HBLANK_ADD     = 8'h04;
endpackage : lptpc_pkg
`default_nettype wire

// File: bench/lptpc_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
module lptpc_panel_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        line_pulse,
	input  wire logic        frame_pulse,
	input  wire logic        panel_data_enable,
	output logic      [15:0] de_len,
	output logic      [15:0] gap_len,
	output logic      [15:0] lp_delay,
	output logic      [15:0] lines,
	output logic      [15:0] fp_lines,
	output logic      [15:0] frame_cnt
);
	logic [15:0] run_cnt;
	logic [15:0] since_de;
	logic [15:0] line_cnt;
	logic [15:0] lp_cnt;
	logic        de_q;
	logic        lp_q;
	logic        fp_q;
	// the panel only listens; every figure is taken at the clock so all share one skew
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{run_cnt, since_de, line_cnt, lp_cnt, de_len, gap_len} <= '0;
			{lp_delay, lines, fp_lines, frame_cnt} <= '0;
			{de_q, lp_q, fp_q} <= '0;
		end else begin
			de_q <= panel_data_enable;
			lp_q <= line_pulse;
			fp_q <= frame_pulse;
			run_cnt <= (panel_data_enable == de_q) ? run_cnt + 16'h1 : 16'h1;
			since_de <= panel_data_enable ? 16'h0 : since_de + 16'h1;
			if (de_q && !panel_data_enable)
				de_len <= run_cnt;
			if (!de_q && panel_data_enable)
				gap_len <= run_cnt;
			// only the first pulse after data is measured; blank lines have no data edge
			if (line_pulse && !lp_q && lp_cnt == 16'h0)
				lp_delay <= since_de;
			// line pulses after the last data line, until the frame pulse
			if (panel_data_enable)
				lp_cnt <= 16'h0;
			else if (line_pulse && !lp_q)
				lp_cnt <= lp_cnt + 16'h1;
			if (frame_pulse && !fp_q) begin
				fp_lines <= lp_cnt;
				lines <= line_cnt;
				line_cnt <= 16'h0;
				frame_cnt <= frame_cnt + 16'h1;
			end else if (!de_q && panel_data_enable)
				line_cnt <= line_cnt + 16'h1;
		end
	end
endmodule : lptpc_panel_model
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import lptpc_pkg::*;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        ext_pin;
	logic        pin_lvl;
	logic        pin_out;
	logic        pin_oe;
	logic        pwr;
	logic        lp;
	logic        fp;
	logic        de;
	logic [15:0] de_len, gap_len, lp_delay, lines, fp_lines, frame_cnt;
	logic [31:0] rd;
	logic        err;
	int          error_cnt;
	int          checks;
	// pin wire: the design wins while it drives, else the outside source
	assign pin_lvl = pin_oe ? pin_out : ext_pin;
	lptpc_top i_lptpc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .shared_pin_zero_in(pin_lvl), .shared_pin_zero_out(pin_out),
		.shared_pin_zero_oe(pin_oe), .panel_power_out(pwr), .line_pulse(lp),
		.frame_pulse(fp), .panel_data_enable(de));
	lptpc_panel_model i_lptpc_panel_model (.pclk(pclk), .presetn(presetn), .line_pulse(lp),
		.frame_pulse(fp), .panel_data_enable(de), .de_len(de_len), .gap_len(gap_len),
		.lp_delay(lp_delay), .lines(lines), .fp_lines(fp_lines), .frame_cnt(frame_cnt));
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	// one transfer; the request stands until pready is seen high
	task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
		apb(1'b1, idx, wd);
	endtask : wr
	task automatic rchk(input logic [7:0] idx, input logic [31:0] exp, input string name);
		apb(1'b0, idx, 32'h0);
		chk(name, exp, rd);
	endtask : rchk
	task automatic wait_pwr(input logic lvl, input int lim);
		for (int n = 0; n < lim && pwr !== lvl; n++) @(posedge pclk);
		chk("panel_power_out", {31'h0, lvl}, {31'h0, pwr});
	endtask : wait_pwr
	// two frames, so the panel figures come from one clean frame
	task automatic wait_frames;
		logic [15:0] f;
		f = frame_cnt;
		for (int n = 0; n < 3000 && frame_cnt !== f + 16'h2; n++) @(posedge pclk);
		chk("frames", {16'h0, f + 16'h2}, {16'h0, frame_cnt});
	endtask : wait_frames
	task automatic wrap_up;
		if (error_cnt == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up
	// 125 MHz clock
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// hang guard, well beyond the few thousand cycles the tests take
	initial begin
		repeat (40000) @(posedge pclk);
		error_cnt++;
		wrap_up();
	end
	// main sequence; geometry goes in at once, while the free-running counters are small
	initial begin
		{presetn, psel, penable, pwrite, ext_pin, err} = '0;
		{paddr, pwdata, rd} = '0;
		error_cnt = 0;
		checks = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rchk(IDX_HSIZE, 32'h27, "hsize");
		rchk(IDX_VSIZE_LO, 32'hef, "vsize_lo");
		rchk(IDX_FRAME_START, 32'h1, "frame_start");
		wr(IDX_HSIZE, 32'h3);
		wr(IDX_VSIZE_HI, 32'hff);
		rchk(IDX_VSIZE_HI, 32'h3, "vsize_hi");
		wr(IDX_VSIZE_HI, 32'h0);
		wr(IDX_VSIZE_LO, 32'h3);
		wr(IDX_HBLANK, 32'h2);
		wr(IDX_VBLANK, 32'h2);
		apb(1'b0, 8'h02, 32'h0);
		chk("unmapped", 32'h1, {31'h0, err});
		chk("off_outputs", 32'h0, {28'h0, pwr, lp, fp, de});
		for (int c = 0; c < 4; c++) begin
			wr(IDX_POWER_SAVE, 32'(c));
			apb(1'b0, IDX_STATUS, 32'h0);
			chk("power_save", {31'h0, c == 0}, {31'h0, rd[0]});
		end
		wait_pwr(1'b1, 1000);
		wait_frames();
		chk("active_px", 32'd32, {16'h0, de_len});
		chk("blank_px", 32'd48, {16'h0, gap_len});
		chk("lines", 32'd4, {16'h0, lines});
		chk("passive_lp", 32'd0, {16'h0, lp_delay});
		chk("passive_fp", 32'd1, {16'h0, fp_lines});
		wr(IDX_PANEL_TYPE, 32'h80);
		wr(IDX_LINE_START, 32'h1);
		wr(IDX_FRAME_START, 32'h2);
		wait_frames();
		chk("lp_delay", 32'd24, {16'h0, lp_delay});
		chk("fp_lines", 32'd2, {16'h0, fp_lines});
		ext_pin <= 1'b1;
		wr(IDX_PIN_CFG, 32'h1);
		wr(IDX_PIN_CTL, 32'h0);
		repeat (3) @(posedge pclk);
		apb(1'b0, IDX_STATUS, 32'h0);
		chk("pin_drive0", 32'h4, {29'h0, pin_oe, pin_out, rd[2]});
		wr(IDX_PIN_CTL, 32'h1);
		chk("pin_drive1", 32'h3, {30'h0, pin_oe, pin_out});
		wr(IDX_PIN_CFG, 32'h0);
		repeat (3) @(posedge pclk);
		apb(1'b0, IDX_STATUS, 32'h0);
		chk("pin_input", 32'h1, {30'h0, pin_oe, rd[2]});
		ext_pin <= 1'b0;
		rchk(IDX_PIN_CTL, 32'h0, "pin_status");
		wr(IDX_PIN_CFG, 32'h1);
		wr(IDX_POWER_SAVE, 32'h7);
		chk("hw_ps_oe", 32'h0, {31'h0, pin_oe});
		// start just after a frame end, so the hold check is far from the next one
		while (fp !== 1'b1) @(posedge pclk);
		while (fp !== 1'b0) @(posedge pclk);
		ext_pin <= 1'b1;
		repeat (4) @(posedge pclk);
		chk("seq_hold", 32'h1, {31'h0, pwr});
		wait_pwr(1'b0, 1000);
		ext_pin <= 1'b0;
		wait_pwr(1'b1, 1000);
		wr(IDX_POWER_SAVE, 32'hf);
		ext_pin <= 1'b1;
		wait_pwr(1'b0, 6);
		chk("forced_low", 32'h0, {29'h0, lp, fp, de});
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
